// ===== hw/ddr2_core_interface.v
// Operation
// - Core moves 4n word; pins move n per half-cycle.
// - Device drives strobes on reads, controller on writes.
// - Read strobe edge-aligned; write strobe centre-aligned.
// - Lower and upper byte have separate strobes.
// - Commands sampled at positive clock crossing.
// - Write data on both strobe edges; reads both edges.
// - Bursts run from start column in programmed order.
// - Activate bank and address pick bank and row.
// - Read/write bank and address pick start column.
// - Burst length four or eight, shared by both.
// - New read/write cuts an eight-beat burst short.
// - Auto precharge closes row after burst ends.
// - Banks work concurrently, independently of each other.
// - Self refresh mode and separate power-down mode.
// - Two byte lanes, each with own mask, strobe.
// - Behaviour defined with delay-locked loop enabled.
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "ddr2_core_defs.vh"
module ddr2_core_interface #(
	parameter ROWB = 4,
	parameter COLB = 4
) (
	input  wire        clk,
	input  wire        rst,
	input  wire        ck,
	input  wire        ckN,
	input  wire        cke,
	input  wire        csN,
	input  wire        rasN,
	input  wire        casN,
	input  wire        weN,
	input  wire [1:0]  ba,
	input  wire [13:0] addr,
	input  wire [15:0] dqIn,
	output wire [15:0] dqOut,
	output wire [1:0]  dqOe,
	input  wire [1:0]  dqsIn,
	output wire [1:0]  dqsOut,
	output wire [1:0]  dqsOe,
	input  wire [1:0]  dm,
	input  wire [3:0]  awaddr,
	input  wire        awvalid,
	output wire        awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output wire        wready,
	output wire [1:0]  bresp,
	output wire        bvalid,
	input  wire        bready,
	input  wire [3:0]  araddr,
	input  wire        arvalid,
	output wire        arready,
	output wire [31:0] rdata,
	output wire [1:0]  rresp,
	output wire        rvalid,
	input  wire        rready
);
	localparam MODE_NORM = 2'b00;
	localparam MODE_PDN  = 2'b01;
	localparam MODE_SREF = 2'b10;
	localparam IW        = ROWB + COLB;

	reg        ckS1_reg, ckS2_reg, ckS3_reg, ckNS1_reg, ckNS2_reg;
	reg [20:0] cmdS1_reg, cmdS2_reg;
	reg [19:0] datS1_reg, datS2_reg;
	reg [1:0]  dqsPrev_reg;
	reg [7:0]  ctrl_reg;
	reg [1:0]  mode_reg;
	reg [3:0]  bankOpen_reg;
	reg [ROWB-1:0] openRow_reg [0:3];
	reg [63:0] mem [0:(1<<IW)-1];
	reg        rdPend_reg, rdBurst_reg, pAp_reg, aAp_reg;
	reg [2:0]  rdWait_reg;
	reg [1:0]  pBank_reg, aBank_reg;
	reg [ROWB-1:0] pRow_reg, aRow_reg;
	reg [COLB-1:0] pCol_reg, aCol_reg;
	reg [3:0]  rdBeat_reg;
	reg [15:0] dqOut_reg;
	reg [1:0]  dqOe_reg, dqsOut_reg, dqsOe_reg;
	reg        wrActive_reg, wrAp_reg;
	reg [1:0]  wrBank_reg;
	reg [ROWB-1:0] wrRow_reg;
	reg [COLB-1:0] wrCol_reg;
	reg [3:0]  wrBeat0_reg, wrBeat1_reg;
	reg        awReady_reg, wReady_reg, bValid_reg, arReady_reg, rValid_reg, wStrb0_reg;
	reg [1:0]  bResp_reg, rResp_reg;
	reg [3:0]  awAddr_reg;
	reg [7:0]  wData_reg;
	reg [31:0] rData_reg;

	// Column of a given beat: sequential or interleaved, wrapping inside the burst.
	function [COLB-1:0] beatCol;
		input [COLB-1:0] s;
		input [2:0]      b;
		input            bl8;
		input            ilv;
		reg   [2:0]      o;
		begin
			if (ilv)
				o = s[2:0] ^ b;
			else
				o = s[2:0] + b;
			if (!bl8)
				o[2] = s[2];
			beatCol = {s[COLB-1:3], o};
		end
	endfunction

	// Prefetch word index: four beats of one lane pair share one core word.
	function [IW-1:0] memIdx;
		input [1:0]      b;
		input [ROWB-1:0] r;
		input [COLB-1:0] c;
		begin
			memIdx = {b, r, c[COLB-1:2]};
		end
	endfunction

	// Decoded control fields and synchronised pin views.
	wire       bl8      = ctrl_reg[`CTRL_BL8];
	wire       ilv      = ctrl_reg[`CTRL_ILV];
	wire       dllOn    = ctrl_reg[`CTRL_DLL];
	wire [2:0] cl       = ctrl_reg[`CTRL_CL_LO +: 3];
	wire [3:0] burstLen = bl8 ? `BL8_LEN : `BL4_LEN;
	wire       ckRise   = ckS2_reg & ~ckS3_reg & ~ckNS2_reg;
	wire       ckEdge   = ckS2_reg ^ ckS3_reg;
	wire       sCke     = cmdS2_reg[20];
	wire       sCsN     = cmdS2_reg[19];
	wire [2:0] sCmd     = cmdS2_reg[18:16];
	wire [1:0] sBa      = cmdS2_reg[15:14];
	wire [13:0] sAddr   = cmdS2_reg[13:0];
	wire [1:0] sDqs     = datS2_reg[19:18];
	wire [1:0] sDm      = datS2_reg[17:16];
	wire [15:0] sDq     = datS2_reg[15:0];
	wire [1:0] dqsEdge  = sDqs ^ dqsPrev_reg;
	wire       cmdOk    = ckRise & ~sCsN & sCke & (mode_reg == MODE_NORM);
	wire       rdCmd    = cmdOk & (sCmd == `CMD_RD) & bankOpen_reg[sBa];
	wire       wrCmd    = cmdOk & (sCmd == `CMD_WR) & bankOpen_reg[sBa];

	// Read source: the pending burst on its first beat, else the running one.
	wire       rdStart  = ckRise & rdPend_reg & (rdWait_reg <= 3'h1);
	wire [1:0] srcBank  = rdStart ? pBank_reg : aBank_reg;
	wire [ROWB-1:0] srcRow = rdStart ? pRow_reg : aRow_reg;
	wire [COLB-1:0] srcCol = rdStart ? pCol_reg : aCol_reg;
	wire [3:0] srcBeat  = rdStart ? 4'h0 : rdBeat_reg;
	wire [COLB-1:0] rCol = beatCol(srcCol, srcBeat[2:0], bl8, ilv);
	wire [63:0] rWord   = mem[memIdx(srcBank, srcRow, rCol)];
	wire [15:0] rBeat   = rWord[{rCol[1:0], 4'h0} +: 16];
	wire       rdEnd    = ckEdge & rdBurst_reg & ~rdStart & (rdBeat_reg == burstLen);

	// Write lanes: each lane counts its own strobe edges.
	wire [COLB-1:0] wCol0 = beatCol(wrCol_reg, wrBeat0_reg[2:0], bl8, ilv);
	wire [COLB-1:0] wCol1 = beatCol(wrCol_reg, wrBeat1_reg[2:0], bl8, ilv);
	wire       wTake0   = wrActive_reg & dqsEdge[0] & (wrBeat0_reg < burstLen);
	wire       wTake1   = wrActive_reg & dqsEdge[1] & (wrBeat1_reg < burstLen);
	wire       wrEnd    = wrActive_reg & (wrBeat0_reg == burstLen) & (wrBeat1_reg == burstLen);

	// Two-flop synchronisers for every pin, plus the edge-detect stage.
	always @(posedge clk) begin
		ckS1_reg    <= ck;
		ckS2_reg    <= ckS1_reg;
		ckS3_reg    <= ckS2_reg;
		ckNS1_reg   <= ckN;
		ckNS2_reg   <= ckNS1_reg;
		cmdS1_reg   <= {cke, csN, rasN, casN, weN, ba, addr};
		cmdS2_reg   <= cmdS1_reg;
		datS1_reg   <= {dqsIn, dm, dqIn};
		datS2_reg   <= datS1_reg;
		dqsPrev_reg <= sDqs;
	end

	// Power state: low clock enable enters power-down, or self refresh with a refresh.
	always @(posedge clk) begin
		if (rst) begin
			mode_reg <= MODE_NORM;
		end else if (ckRise) begin
			case (mode_reg)
				MODE_NORM: begin
					if (!sCke)
						mode_reg <= (!sCsN && sCmd == `CMD_REF) ? MODE_SREF : MODE_PDN;
				end
				MODE_PDN, MODE_SREF: begin
					if (sCke)
						mode_reg <= MODE_NORM;
				end
				default: begin
					mode_reg <= MODE_NORM;
				end
			endcase
		end
	end

	// Per-bank open state; each bank opens on its own, and closes on its own or with all others by an all-bank precharge.
	always @(posedge clk) begin
		if (rst) begin
			bankOpen_reg <= 4'h0;
		end else begin
			if (cmdOk && sCmd == `CMD_ACT) begin
				bankOpen_reg[sBa] <= 1'b1;
				openRow_reg[sBa]  <= sAddr[ROWB-1:0];
			end
			if (cmdOk && sCmd == `CMD_PRE) begin
				if (sAddr[`AP_BIT])
					bankOpen_reg <= 4'h0;
				else
					bankOpen_reg[sBa] <= 1'b0;
			end
			if (rdEnd && aAp_reg)
				bankOpen_reg[aBank_reg] <= 1'b0;
			if (wrEnd && wrAp_reg)
				bankOpen_reg[wrBank_reg] <= 1'b0;
		end
	end

	// Read path: wait the latency, then one beat and one strobe level per clock edge.
	always @(posedge clk) begin
		if (rst) begin
			rdPend_reg  <= 1'b0;
			rdBurst_reg <= 1'b0;
			rdWait_reg  <= 3'h0;
			rdBeat_reg  <= 4'h0;
			dqOut_reg   <= 16'h0000;
			dqOe_reg    <= 2'h0;
			dqsOut_reg  <= 2'h0;
			dqsOe_reg   <= 2'h0;
		end else begin
			if (ckRise && rdPend_reg && !rdStart)
				rdWait_reg <= rdWait_reg - 3'h1;
			if (rdStart) begin
				rdPend_reg  <= 1'b0;
				rdBurst_reg <= 1'b1;
				aBank_reg   <= pBank_reg;
				aRow_reg    <= pRow_reg;
				aCol_reg    <= pCol_reg;
				aAp_reg     <= pAp_reg;
			end
			if (ckEdge && (rdStart || (rdBurst_reg && rdBeat_reg < burstLen))) begin
				dqOut_reg  <= rBeat;
				dqsOut_reg <= {ckRise, ckRise};
				dqOe_reg   <= 2'h3;
				dqsOe_reg  <= 2'h3;
				rdBeat_reg <= srcBeat + 4'h1;
			end
			if (rdEnd) begin
				rdBurst_reg <= 1'b0;
				dqOe_reg    <= 2'h0;
				dqsOe_reg   <= 2'h0;
				dqsOut_reg  <= 2'h0;
			end
			if (rdCmd) begin
				rdPend_reg <= 1'b1;
				rdWait_reg <= cl;
				pBank_reg  <= sBa;
				pRow_reg   <= openRow_reg[sBa];
				pCol_reg   <= sAddr[COLB-1:0];
				pAp_reg    <= sAddr[`AP_BIT];
			end
		end
	end

	// Write path: capture each lane on both strobe edges until the burst is full.
	always @(posedge clk) begin
		if (rst) begin
			wrActive_reg <= 1'b0;
			wrBeat0_reg  <= 4'h0;
			wrBeat1_reg  <= 4'h0;
		end else begin
			if (wTake0)
				wrBeat0_reg <= wrBeat0_reg + 4'h1;
			if (wTake1)
				wrBeat1_reg <= wrBeat1_reg + 4'h1;
			if (wrEnd)
				wrActive_reg <= 1'b0;
			if (wrCmd) begin
				wrActive_reg <= 1'b1;
				wrBeat0_reg  <= 4'h0;
				wrBeat1_reg  <= 4'h0;
				wrBank_reg   <= sBa;
				wrRow_reg    <= openRow_reg[sBa];
				wrCol_reg    <= sAddr[COLB-1:0];
				wrAp_reg     <= sAddr[`AP_BIT];
			end
		end
	end

	// Core array: each lane writes its own byte of the prefetch word unless masked.
	always @(posedge clk) begin
		if (wTake0 && !sDm[0])
			mem[memIdx(wrBank_reg, wrRow_reg, wCol0)][{wCol0[1:0], 4'h0} +: 8] <= sDq[7:0];
		if (wTake1 && !sDm[1])
			mem[memIdx(wrBank_reg, wrRow_reg, wCol1)][{wCol1[1:0], 4'h8} +: 8] <= sDq[15:8];
	end

	// AXI4-Lite slave: one write and one read at a time, unmapped answers SLVERR.
	always @(posedge clk) begin
		if (rst) begin
			ctrl_reg    <= `CTRL_RESET;
			awReady_reg <= 1'b1;
			wReady_reg  <= 1'b1;
			bValid_reg  <= 1'b0;
			bResp_reg   <= `RESP_OK;
			arReady_reg <= 1'b1;
			rValid_reg  <= 1'b0;
			rResp_reg   <= `RESP_OK;
			rData_reg   <= 32'h00000000;
		end else begin
			if (awvalid && awReady_reg) begin
				awAddr_reg  <= awaddr;
				awReady_reg <= 1'b0;
			end
			if (wvalid && wReady_reg) begin
				wData_reg  <= wdata[7:0];
				wStrb0_reg <= wstrb[0];
				wReady_reg <= 1'b0;
			end
			if (!awReady_reg && !wReady_reg && !bValid_reg) begin
				bValid_reg <= 1'b1;
				bResp_reg  <= (awAddr_reg == `REG_CTRL || awAddr_reg == `REG_STATUS) ? `RESP_OK : `RESP_ERR;
				if (awAddr_reg == `REG_CTRL && wStrb0_reg)
					ctrl_reg <= wData_reg;
			end
			if (bValid_reg && bready) begin
				bValid_reg  <= 1'b0;
				awReady_reg <= 1'b1;
				wReady_reg  <= 1'b1;
			end
			if (arvalid && arReady_reg) begin
				arReady_reg <= 1'b0;
				rValid_reg  <= 1'b1;
				rResp_reg   <= `RESP_OK;
				case (araddr)
					`REG_CTRL: rData_reg <= {24'h000000, ctrl_reg};
					`REG_STATUS: rData_reg <= {24'h000000, ~dllOn, rdPend_reg | rdBurst_reg | wrActive_reg,
						mode_reg, bankOpen_reg};
					default: begin
						rData_reg <= 32'h00000000;
						rResp_reg <= `RESP_ERR;
					end
				endcase
			end
			if (rValid_reg && rready) begin
				rValid_reg  <= 1'b0;
				arReady_reg <= 1'b1;
			end
		end
	end

	// Outputs come straight from flip-flops.
	assign dqOut   = dqOut_reg;
	assign dqOe    = dqOe_reg;
	assign dqsOut  = dqsOut_reg;
	assign dqsOe   = dqsOe_reg;
	assign awready = awReady_reg;
	assign wready  = wReady_reg;
	assign bresp   = bResp_reg;
	assign bvalid  = bValid_reg;
	assign arready = arReady_reg;
	assign rdata   = rData_reg;
	assign rresp   = rResp_reg;
	assign rvalid  = rValid_reg;
endmodule

// ===== hw/ddr2_core_defs.vh
// Constants for the DDR2-style memory core interface.
`ifndef DDR2_CORE_DEFS_VH
`define DDR2_CORE_DEFS_VH
`define REG_CTRL    4'h0
`define REG_STATUS  4'h4
`define CTRL_BL8    0
`define CTRL_ILV    1
`define CTRL_DLL    2
`define CTRL_CL_LO  4
`define CTRL_RESET  8'h34
`define CMD_ACT     3'h3
`define CMD_RD      3'h5
`define CMD_WR      3'h4
`define CMD_PRE     3'h2
`define CMD_REF     3'h1
`define AP_BIT      10
`define BL8_LEN     4'h8
`define BL4_LEN     4'h4
`define RESP_OK     2'h0
`define RESP_ERR    2'h2
`endif

// ===== tb/ddr2_core_interface_assertions.sv
// Checker of the memory core interface port behaviour.
`timescale 1ns/1ns
module ddr2_core_checker (
	input logic        clk,
	input logic        rst,
	input logic [15:0] dqOut,
	input logic [1:0]  dqOe,
	input logic [1:0]  dqsOut,
	input logic [1:0]  dqsOe,
	input logic        awvalid,
	input logic        awready,
	input logic        wvalid,
	input logic        wready,
	input logic [1:0]  bresp,
	input logic        bvalid,
	input logic        bready,
	input logic        arvalid,
	input logic        arready,
	input logic [31:0] rdata,
	input logic [1:0]  rresp,
	input logic        rvalid,
	input logic        rready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Pin drivers and bus answers are quiet after a reset edge.
	AST_RST_IDLE: assert property (disable iff (1'b0) rst |=> dqOe == 2'h0 && !bvalid && !rvalid)
		else $error("outputs active after reset");
	AST_OE_PAIR: assert property (dqsOe == dqOe)
		else $error("strobe and data enables differ");
	AST_LANES: assert property (dqsOe != 2'h0 |->
		dqOe == 2'h3 && (dqsOut == 2'h0 || dqsOut == 2'h3))
		else $error("byte lanes out of step");
	AST_EDGE_ALIGN: assert property (&dqOe && &$past(dqOe) && $changed(dqOut) |-> $changed(dqsOut))
		else $error("read data moved without a strobe edge");
	AST_BEAT_LEN: assert property (dqsOe == 2'h3 && $changed(dqsOut) |=>
		$stable(dqsOut) [*3])
		else $error("read beat shorter than half a memory clock");
	AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read response dropped");
	AST_AR_ANS: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	// The response is raised at the edge after both handshakes, so it is seen two edges on.
	AST_B_ANS: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
		else $error("write answer late");
endmodule
bind ddr2_core_interface ddr2_core_checker chkI (.clk, .rst, .dqOut, .dqOe, .dqsOut, .dqsOe, .awvalid, .awready,
	.wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

// ===== tb/ddr2_ctl_model.sv
// Behavioural memory controller that drives clock, commands and write bursts.
`timescale 1ns/1ns
module ddr2_ctl_model (
	output logic        ck,
	output logic        ckN,
	output logic        cke,
	output logic        csN,
	output logic        rasN,
	output logic        casN,
	output logic        weN,
	output logic [1:0]  ba,
	output logic [13:0] addr,
	output logic [15:0] dq,
	output logic [1:0]  dqs,
	output logic [1:0]  dm
);
	assign ckN = ~ck;
	// The memory clock runs free, offset so its edges never meet the system clock.
	initial begin
		{ck, dqs, dm, ba, addr, dq} = '0;
		{cke, csN, rasN, casN, weN} = 5'h1f;
		#7;
		forever #160 ck = ~ck;
	end
	// One command centred on a rising edge, then a deselect with the address inverted.
	task issue(input [2:0] c, input [1:0] b, input [13:0] a, input k);
		@(negedge ck);
		csN = (c == 3'h7);
		{rasN, casN, weN} = c;
		{ba, addr, cke} = {b, a, k};
		@(negedge ck);
		csN = 1'b1;
		{rasN, casN, weN} = 3'h7;
		{ba, addr} = ~{b, a};
	endtask
	// Each beat sits centred on a strobe edge on both lanes; the bus is inverted after.
	task wr(input [3:0] base, input int n);
		for (int k = 0; k < n; k++) begin
			dq = {base, k[3:0], 4'h5, k[3:0]};
			#80 dqs = ~dqs;
			#80;
		end
		dq = ~dq;
	endtask
endmodule

// ===== tb/ddr2_core_interface_tb.sv
// Self-checking bench of the memory core interface.
`timescale 1ns/1ns
`include "ddr2_core_defs.vh"
module ddr2_core_interface_tb;
	logic        clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [3:0]  awaddr = 0, araddr = 0, wstrb = 4'hf;
	logic [31:0] wdata = 0, d;
	logic [1:0]  r, pq = 0, po = 0;
	logic [15:0] beats[$];
	logic [51:0] rows[5];
	int          err_count = 0, n_compared = 0, cyc = 0;
	wire [15:0]  dqOut, ctlDq, dqIn;
	wire [13:0]  addr;
	wire [31:0]  rdata;
	wire [1:0]   dqOe, dqsOut, dqsOe, ctlDqs, dqsIn, bresp, rresp, ba, dm;
	wire         awready, wready, bvalid, arready, rvalid, ck, ckN, cke, csN, rasN, casN, weN;
	// Shared wires take the device value on lanes it drives.
	assign dqIn = {dqOe[1] ? dqOut[15:8] : ctlDq[15:8], dqOe[0] ? dqOut[7:0] : ctlDq[7:0]};
	assign dqsIn = (dqsOe & dqsOut) | (~dqsOe & ctlDqs);
	ddr2_core_interface dut (.clk, .rst, .ck, .ckN, .cke, .csN, .rasN, .casN, .weN, .ba, .addr, .dqIn, .dqOut,
		.dqOe, .dqsIn, .dqsOut, .dqsOe, .dm, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	ddr2_ctl_model ctl (.ck, .ckN, .cke, .csN, .rasN, .casN, .weN, .ba, .addr, .dq(ctlDq), .dqs(ctlDqs), .dm);
	always #20 clk = ~clk;
	// A read beat is taken whenever the strobe moves while both lanes drive.
	always @(posedge clk) begin
		if (dqOe === 2'h3 && (dqsOut !== pq || po !== 2'h3))
			beats.push_back(dqOut);
		pq <= dqsOut;
		po <= dqOe;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			stop_test;
		end
	end
	function logic [15:0] pat(input [1:0] b, input [3:0] c);
		return {4'ha + {2'h0, b}, c, 4'h5, c};
	endfunction
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task axw(input [3:0] a, input [31:0] v, input [1:0] er);
		@(posedge clk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
		do begin
			@(posedge clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid);
		chk("bresp", er, bresp);
		bready <= 0;
	endtask
	task axr(input [3:0] a);
		@(posedge clk);
		{araddr, arvalid, rready} <= {a, 2'h3};
		do begin
			@(posedge clk);
			if (arready) arvalid <= 0;
		end while (!rvalid);
		{d, r} = {rdata, rresp};
		rready <= 0;
	endtask
	task stat(input [31:0] m, input [31:0] e);
		repeat (8) @(posedge clk);
		axr(`REG_STATUS);
		chk("status", e, d & m);
	endtask
	task rd(input [1:0] b, input [3:0] c, input ap, input int n);
		ctl.issue(`CMD_RD, b, {3'h0, ap, 6'h0, c}, 1'b1);
		for (int i = 0; i < 400 && beats.size() < n; i++) @(posedge clk);
		repeat (40) @(posedge clk);
		chk("beat count", n, beats.size());
	endtask
	task stop_test;
		$display("mismatches %0d comparisons %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Reset value and bus errors, then table cases, then auto precharge, interruption, precharge, modes and reset by hand.
	initial begin
		rows = '{52'h34_0_5_4_56740000, 52'h36_2_5_4_54760000, 52'h35_0_3_8_34567012,
			52'h37_2_3_8_32107654, 52'h25_0_0_8_01234567};
		repeat (2) @(posedge clk);
		rst <= 0;
		axr(`REG_CTRL);
		chk("ctrl reset", `CTRL_RESET, d);
		axr(4'h8);
		chk("unmapped read", {30'h0, `RESP_ERR}, {d[29:0], r});
		axw(4'hc, 32'h1, `RESP_ERR);
		axw(`REG_STATUS, 32'hff, `RESP_OK);
		axw(`REG_CTRL, 32'h35, `RESP_OK);
		ctl.issue(`CMD_ACT, 2'h0, 14'h1, 1'b1);
		ctl.issue(`CMD_ACT, 2'h2, 14'h3, 1'b1);
		ctl.issue(`CMD_WR, 2'h0, 14'h0, 1'b1);
		ctl.wr(4'ha, 8);
		ctl.issue(`CMD_WR, 2'h2, 14'h0, 1'b1);
		ctl.wr(4'hc, 8);
		stat(32'hff, 32'h05);
		foreach (rows[i]) begin
			axw(`REG_CTRL, rows[i][51:44], `RESP_OK);
			rd(rows[i][41:40], rows[i][39:36], 1'b0, rows[i][35:32]);
			for (int k = 0; k < rows[i][35:32]; k++)
				chk("beat", pat(rows[i][41:40], rows[i][31-4*k -: 4]), beats[k]);
			beats = {};
		end
		rd(2'h2, 4'h0, 1'b1, 8);
		beats = {};
		stat(32'h0f, 32'h01);
		// Two reads two memory clocks apart: with latency two the second cuts the first after four beats.
		ctl.issue(`CMD_RD, 2'h0, 14'h0, 1'b1);
		rd(2'h0, 4'h4, 1'b0, 12);
		for (int k = 0; k < 12; k++)
			chk("cut beat", pat(2'h0, k & 7), beats[k]);
		beats = {};
		// Single-bank and all-bank precharge, then a read to a closed bank that must stay silent.
		ctl.issue(`CMD_ACT, 2'h1, 14'h2, 1'b1);
		ctl.issue(`CMD_PRE, 2'h0, 14'h0, 1'b1);
		stat(32'h0f, 32'h02);
		ctl.issue(`CMD_PRE, 2'h3, 14'h400, 1'b1);
		stat(32'h0f, 32'h00);
		rd(2'h0, 4'h0, 1'b0, 0);
		beats = {};
		ctl.issue(3'h7, 2'h0, 14'h0, 1'b0);
		stat(32'h30, 32'h10);
		ctl.issue(3'h7, 2'h0, 14'h0, 1'b1);
		ctl.issue(`CMD_REF, 2'h0, 14'h0, 1'b0);
		stat(32'h30, 32'h20);
		ctl.issue(3'h7, 2'h0, 14'h0, 1'b1);
		stat(32'h30, 32'h00);
		axw(`REG_CTRL, 32'h31, `RESP_OK);
		stat(32'h80, 32'h80);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		axr(`REG_CTRL);
		chk("ctrl after reset", `CTRL_RESET, d);
		stop_test;
	end
endmodule
